// ---- rtl/bmwd_consts.svh ----
/*
  Offsets, field positions, reset values and codes for the bridge memory-window decoder.
  Assumes it is included by its bare name after the package; it holds definitions only.
*/
`ifndef BMWD_CONSTS_SVH
`define BMWD_CONSTS_SVH

// Printed byte offsets; the 16-bit registers share 32-bit configuration dwords
`define BMWD_OFF_MMIO_BASE 8'h20
`define BMWD_OFF_MMIO_LIMIT 8'h22
`define BMWD_OFF_PREF_BASE 8'h24
`define BMWD_OFF_PREF_LIMIT 8'h26
`define BMWD_OFF_PREF_BASE_UPPER 8'h28
`define BMWD_OFF_PREF_LIMIT_UPPER 8'h2C

// Address field of each 16-bit window register
`define BMWD_ADDR_FIELD_MSB 15
`define BMWD_ADDR_FIELD_LSB 4
`define BMWD_ADDR_FIELD_W 12

// Host address slice that the windows compare against
`define BMWD_WIN_ADDR_MSB 31
`define BMWD_WIN_ADDR_LSB 20

// Implied low address bits of base and limit
`define BMWD_BASE_LOW_FILL 20'h00000
`define BMWD_LIMIT_LOW_FILL 20'hFFFFF

// Prefetchable width codes
`define BMWD_WIDTH_CODE_32 4'h0
`define BMWD_WIDTH_CODE_64 4'h1
`define BMWD_WIDTH_CODE_RESET 4'h1

// Reset values of the writable fields
`define BMWD_ADDR_FIELD_RESET 12'h000
`define BMWD_UPPER_RESET 32'h0000_0000

`endif

// ---- rtl/bmwd_pkg.sv ----
/*
  Types of the bridge memory-window decoder: configuration access, host request, claim.
  Assumes nothing of its surroundings; numbers live in bmwd_consts.svh.
*/
package bmwd_pkg;

  // One configuration dword access, byte address with byte enables
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bmwd_cfg_req_type;

  // One host memory access presented for decoding
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } bmwd_mem_req_type;

  // Decode result toward the PCI Express port
  typedef struct packed {
    logic valid;
    logic mmio_hit;
    logic pref_hit;
    logic [63:0] addr;
  } bmwd_fwd_type;

endpackage

// ---- rtl/bmwd_mmio_cmp.sv ----
/*
  Non-prefetchable window compare: 32-bit window on 1 MB granules, combinational.
  Assumes base and limit come from the register file on the same clock.
*/
`include "bmwd_consts.svh"

module bmwd_mmio_cmp (
  input wire logic [11:0] base,
  input wire logic [11:0] limit,
  input wire logic [63:0] addr,
  output logic hit
);

  logic [31:0] lo_bound;
  logic [31:0] hi_bound;

  assign lo_bound = {base, `BMWD_BASE_LOW_FILL};
  assign hi_bound = {limit, `BMWD_LIMIT_LOW_FILL};

  assign hit = (addr[63:32] == 32'h0000_0000) && (addr[31:0] >= lo_bound) &&
               (addr[31:0] <= hi_bound);

endmodule

// ---- rtl/bmwd_pref_cmp.sv ----
/*
  Prefetchable window compare over a 64-bit address, combinational.
  Assumes upper halves are already forced to zero when only 32-bit addressing is offered.
*/
`include "bmwd_consts.svh"

module bmwd_pref_cmp (
  input wire logic [11:0] base,
  input wire logic [11:0] limit,
  input wire logic [31:0] base_upper,
  input wire logic [31:0] limit_upper,
  input wire logic [63:0] addr,
  output logic hit
);

  logic [63:0] lo_bound;
  logic [63:0] hi_bound;

  assign lo_bound = {base_upper, base, `BMWD_BASE_LOW_FILL};
  assign hi_bound = {limit_upper, limit, `BMWD_LIMIT_LOW_FILL};

  assign hit = (addr >= lo_bound) && (addr <= hi_bound);

endmodule

// ---- rtl/bmwd_top.sv ----
/*
  Memory-window decoder of a virtual PCI-to-PCI bridge: window registers on a
  configuration dword port, and the claim decision for host memory accesses.
  Assumes the configuration port and host request come from logic on core_clk,
  one access per cycle, and that reset is synchronous and active high.
*/
// Contract
// - Non-prefetchable base is 12 bits at 15:4, matched to A[31:20]; 3:0 read zero.
// - Non-prefetchable base has its low 20 address bits taken as zero.
// - Non-prefetchable limit is 12 bits at 15:4, low 20 bits taken as ones.
// - Accesses inside the inclusive non-prefetchable window go to the port.
// - Non-prefetchable limit bits 3:0 read zero, writes ignored.
// - Forward when prefetchable base <= A[31:20] <= prefetchable limit.
// - Prefetchable base is 12 bits at 15:4, low 20 bits zero.
// - Prefetchable limit is 12 bits at 15:4, low 20 bits ones.
// - Prefetchable base bits 3:0 are a read-only width code, reset 1h.
// - Prefetchable limit bits 3:0 are the same read-only width code, reset 1h.
// - Both width codes always read identical.
// - With 64-bit code, upper registers extend both bounds to 64 bits.
// - Overlaps are neither detected nor prevented; routing then unspecified.
// - All base and limit address fields reset to zero.
// - Upper registers read zero for 32-bit code, read/write for 64-bit.
// - Upper registers supply A[63:32] of the bounds and reset to zero.
`include "bmwd_consts.svh"

module bmwd_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire bmwd_pkg::bmwd_cfg_req_type cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire bmwd_pkg::bmwd_mem_req_type mem_req,
  output bmwd_pkg::bmwd_fwd_type fwd
);

  localparam logic [3:0] WIDTH_CODE = `BMWD_WIDTH_CODE_RESET;
  localparam logic IS_64 = (WIDTH_CODE == `BMWD_WIDTH_CODE_64);

  logic [11:0] mmio_base_ff;
  logic [11:0] mmio_limit_ff;
  logic [11:0] pref_base_ff;
  logic [11:0] pref_limit_ff;
  logic [31:0] pref_base_upper_ff;
  logic [31:0] pref_limit_upper_ff;
  logic [31:0] cfg_rdata_ff;
  logic cfg_ack_ff;
  bmwd_pkg::bmwd_fwd_type fwd_ff;

  logic [31:0] nxt_rdata;
  logic [31:0] base_upper_eff;
  logic [31:0] limit_upper_eff;
  logic mmio_hit;
  logic pref_hit;
  logic wr_mmio;
  logic wr_pref;
  logic wr_bu;
  logic wr_lu;

  // Dword that holds a printed byte offset
  function automatic logic dword_is(input logic [7:0] addr, input logic [7:0] off);
    dword_is = (addr[7:2] == off[7:2]);
  endfunction

  // Writable address field of a 16-bit register from its two byte lanes
  function automatic logic [11:0] field_wr(input logic [11:0] old,
                                           input logic [1:0] be,
                                           input logic [15:0] data);
    logic [11:0] res;
    res = old;
    if (be[0]) begin
      res[3:0] = data[7:4];
    end
    if (be[1]) begin
      res[11:4] = data[15:8];
    end
    field_wr = res;
  endfunction

  // Byte-lane merge of a full 32-bit register
  function automatic logic [31:0] word_wr(input logic [31:0] old,
                                          input logic [3:0] be,
                                          input logic [31:0] data);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    word_wr = res;
  endfunction

  assign wr_mmio = cfg_req.wr && dword_is(cfg_req.addr, `BMWD_OFF_MMIO_BASE);
  assign wr_pref = cfg_req.wr && dword_is(cfg_req.addr, `BMWD_OFF_PREF_BASE);
  assign wr_bu = cfg_req.wr && dword_is(cfg_req.addr, `BMWD_OFF_PREF_BASE_UPPER);
  assign wr_lu = cfg_req.wr && dword_is(cfg_req.addr, `BMWD_OFF_PREF_LIMIT_UPPER);

  // base field writable, low nibble not stored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mmio_base_ff <= `BMWD_ADDR_FIELD_RESET;
    end else if (wr_mmio) begin
      mmio_base_ff <= field_wr(mmio_base_ff, cfg_req.be[1:0], cfg_req.wdata[15:0]);
    end
  end

  // limit low nibble has no storage, so writes there are lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mmio_limit_ff <= `BMWD_ADDR_FIELD_RESET;
    end else if (wr_mmio) begin
      mmio_limit_ff <= field_wr(mmio_limit_ff, cfg_req.be[3:2], cfg_req.wdata[31:16]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pref_base_ff <= `BMWD_ADDR_FIELD_RESET;
      pref_limit_ff <= `BMWD_ADDR_FIELD_RESET;
    end else if (wr_pref) begin
      pref_base_ff <= field_wr(pref_base_ff, cfg_req.be[1:0], cfg_req.wdata[15:0]);
      pref_limit_ff <= field_wr(pref_limit_ff, cfg_req.be[3:2], cfg_req.wdata[31:16]);
    end
  end

  // writable only when 64-bit addressing is offered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pref_base_upper_ff <= `BMWD_UPPER_RESET;
      pref_limit_upper_ff <= `BMWD_UPPER_RESET;
    end else begin
      if (wr_bu && IS_64) begin
        pref_base_upper_ff <= word_wr(pref_base_upper_ff, cfg_req.be, cfg_req.wdata);
      end
      if (wr_lu && IS_64) begin
        pref_limit_upper_ff <= word_wr(pref_limit_upper_ff, cfg_req.be, cfg_req.wdata);
      end
    end
  end

  // 32-bit code hides the upper halves from decode and reads
  assign base_upper_eff = IS_64 ? pref_base_upper_ff : `BMWD_UPPER_RESET;
  assign limit_upper_eff = IS_64 ? pref_limit_upper_ff : `BMWD_UPPER_RESET;

  // Read mux; offsets outside the window set read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (dword_is(cfg_req.addr, `BMWD_OFF_MMIO_BASE)) begin
      nxt_rdata = {mmio_limit_ff, 4'h0, mmio_base_ff, 4'h0};
    end else if (dword_is(cfg_req.addr, `BMWD_OFF_PREF_BASE)) begin
      nxt_rdata = {pref_limit_ff, WIDTH_CODE, pref_base_ff, WIDTH_CODE};
    end else if (dword_is(cfg_req.addr, `BMWD_OFF_PREF_BASE_UPPER)) begin
      nxt_rdata = base_upper_eff;
    end else if (dword_is(cfg_req.addr, `BMWD_OFF_PREF_LIMIT_UPPER)) begin
      nxt_rdata = limit_upper_eff;
    end
  end

  // Read data and ack one cycle after the request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_rdata_ff <= 32'h0000_0000;
    end else if (cfg_req.rd) begin
      cfg_rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_ack_ff <= 1'b0;
    end else begin
      cfg_ack_ff <= cfg_req.rd || cfg_req.wr;
    end
  end

  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_ack = cfg_ack_ff;

  bmwd_mmio_cmp u_mmio_cmp (
    .base(mmio_base_ff),
    .limit(mmio_limit_ff),
    .addr(mem_req.addr),
    .hit(mmio_hit)
  );

  bmwd_pref_cmp u_pref_cmp (
    .base(pref_base_ff),
    .limit(pref_limit_ff),
    .base_upper(base_upper_eff),
    .limit_upper(limit_upper_eff),
    .addr(mem_req.addr),
    .hit(pref_hit)
  );

  // both hits are reported as seen, with no overlap check
  // software keeps windows apart, so a double hit is its fault
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fwd_ff <= '0;
    end else begin
      fwd_ff.valid <= mem_req.valid && (mmio_hit || pref_hit);
      fwd_ff.mmio_hit <= mem_req.valid && mmio_hit;
      fwd_ff.pref_hit <= mem_req.valid && pref_hit;
      fwd_ff.addr <= mem_req.addr;
    end
  end

  assign fwd = fwd_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  base_nibble_zero_a: assert property (
    cfg_req.rd && dword_is(cfg_req.addr, `BMWD_OFF_MMIO_BASE) |=>
      cfg_ack && (cfg_rdata[3:0] == 4'h0))
    else $error("base low nibble not zero");

  base_bottom_hit_a: assert property (
    mem_req.valid && (mem_req.addr[63:32] == 32'h0) &&
    (mem_req.addr[31:20] == mmio_base_ff) && (mmio_base_ff <= mmio_limit_ff) |=>
      fwd.mmio_hit && fwd.valid)
    else $error("base granule not claimed");

  limit_top_hit_a: assert property (
    mem_req.valid && (mem_req.addr[63:32] == 32'h0) &&
    (mem_req.addr[31:20] == mmio_limit_ff) && (mmio_base_ff <= mmio_limit_ff) |=>
      fwd.mmio_hit)
    else $error("limit granule not claimed");

  mmio_route_a: assert property (
    mem_req.valid && (mem_req.addr[63:32] == 32'h0) &&
    (mem_req.addr[31:20] >= mmio_base_ff) && (mem_req.addr[31:20] <= mmio_limit_ff) |=>
      fwd.valid && (fwd.addr == $past(mem_req.addr)))
    else $error("mmio access not forwarded");

  limit_nibble_ro_a: assert property (
    cfg_req.rd && dword_is(cfg_req.addr, `BMWD_OFF_MMIO_LIMIT) |=>
      cfg_ack && (cfg_rdata[19:16] == 4'h0))
    else $error("limit low nibble took a write");

  pref_route_a: assert property (
    mem_req.valid && (mem_req.addr[63:32] == base_upper_eff) &&
    (base_upper_eff == limit_upper_eff) &&
    (mem_req.addr[31:20] >= pref_base_ff) && (mem_req.addr[31:20] <= pref_limit_ff) |=>
      fwd.pref_hit && fwd.valid)
    else $error("prefetch access not forwarded");

  width_codes_a: assert property (
    cfg_req.rd && dword_is(cfg_req.addr, `BMWD_OFF_PREF_BASE) |=>
      (cfg_rdata[3:0] == `BMWD_WIDTH_CODE_RESET) && (cfg_rdata[19:16] == cfg_rdata[3:0]))
    else $error("width codes differ");

  fields_reset_a: assert property (
    $fell(reset) |-> (mmio_base_ff == 12'h000) && (mmio_limit_ff == 12'h000) &&
      (pref_base_ff == 12'h000) && (pref_limit_ff == 12'h000) && !fwd.valid)
    else $error("window fields not reset");

  upper_write_a: assert property (
    wr_bu && (cfg_req.be == 4'hF) |=> ##1
      base_upper_eff == (IS_64 ? $past(cfg_req.wdata, 2) : 32'h0))
    else $error("upper base write lost");

  no_claim_a: assert property (
    mem_req.valid && !mmio_hit && !pref_hit |=> !fwd.valid)
    else $error("unmatched access claimed");

  base_write_lands_a: assert property (
    wr_mmio && cfg_req.be[1] |=> mmio_base_ff[11:4] == $past(cfg_req.wdata[15:8]))
    else $error("base write not stored");

  limit_write_lands_a: assert property (
    wr_mmio && cfg_req.be[3] |=> mmio_limit_ff[11:4] == $past(cfg_req.wdata[31:24]))
    else $error("limit write not stored");

  mmio_below_a: assert property (
    mem_req.valid && (mem_req.addr[31:20] < mmio_base_ff) |=> !fwd.mmio_hit)
    else $error("mmio hit below base");

  mmio_upper_miss_a: assert property (
    mem_req.valid && (mem_req.addr[63:32] != 32'h0) |=> !fwd.mmio_hit)
    else $error("mmio hit above 4 GB");

  pref_above_a: assert property (
    mem_req.valid && (mem_req.addr[63:32] == limit_upper_eff) &&
    (mem_req.addr[31:20] > pref_limit_ff) |=> !fwd.pref_hit)
    else $error("prefetch hit above limit");

  pref_bottom_hit_a: assert property (
    mem_req.valid &&
    (mem_req.addr == {base_upper_eff, pref_base_ff, `BMWD_BASE_LOW_FILL}) &&
    ({base_upper_eff, pref_base_ff} <= {limit_upper_eff, pref_limit_ff}) |=>
      fwd.pref_hit && fwd.valid)
    else $error("prefetch base granule not claimed");

  pref_top_hit_a: assert property (
    mem_req.valid &&
    (mem_req.addr == {limit_upper_eff, pref_limit_ff, `BMWD_LIMIT_LOW_FILL}) &&
    ({base_upper_eff, pref_base_ff} <= {limit_upper_eff, pref_limit_ff}) |=>
      fwd.pref_hit && fwd.valid)
    else $error("prefetch limit granule not claimed");

  base_code_read_a: assert property (
    cfg_req.rd && dword_is(cfg_req.addr, `BMWD_OFF_PREF_BASE) |=>
      cfg_rdata[3:0] == `BMWD_WIDTH_CODE_RESET)
    else $error("base width code wrong");

  limit_code_read_a: assert property (
    cfg_req.rd && dword_is(cfg_req.addr, `BMWD_OFF_PREF_LIMIT) |=>
      cfg_rdata[19:16] == `BMWD_WIDTH_CODE_RESET)
    else $error("limit width code wrong");

  upper_miss_a: assert property (
    mem_req.valid && (base_upper_eff == limit_upper_eff) &&
    (mem_req.addr[63:32] != base_upper_eff) |=> !fwd.pref_hit)
    else $error("prefetch hit outside upper bound");

  limit_upper_write_a: assert property (
    wr_lu && (cfg_req.be == 4'hF) |=>
      limit_upper_eff == (IS_64 ? $past(cfg_req.wdata) : 32'h0))
    else $error("upper limit write lost");

  upper_reset_a: assert property (
    $fell(reset) |-> (base_upper_eff == 32'h0) && (limit_upper_eff == 32'h0))
    else $error("upper halves not reset");

  mmio_hit_c: cover property (mem_req.valid && mmio_hit ##1 fwd.mmio_hit);
  pref_hit_c: cover property (mem_req.valid && pref_hit && (mem_req.addr[63:32] != 32'h0));
  overlap_hit_c: cover property (fwd.mmio_hit && fwd.pref_hit);
  cfg_write_read_c: cover property (wr_mmio ##2 cfg_req.rd ##1 cfg_ack);

endmodule

// ---- testbench/bmwd_host_model.sv ----
/*
  Host-side partner of the window decoder: issues configuration dword accesses and
  host memory accesses, one at a time, and returns what the decoder answered.
  Assumes the decoder takes requests on core_clk rising edges and answers one cycle later.
*/
module bmwd_host_model (
  input wire logic core_clk,
  output bmwd_pkg::bmwd_cfg_req_type cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  output bmwd_pkg::bmwd_mem_req_type mem_req,
  input wire bmwd_pkg::bmwd_fwd_type fwd
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cfg_req = '0;
    mem_req = '0;
  end

  // Released address, enable and data lines show the inverse of their last value, never a stale copy; rd and wr drop to zero
  task automatic cfg_access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                            input logic [31:0] wdata, output logic [31:0] rdata,
                            output logic ack);
    @(posedge core_clk);
    #1;
    cfg_req.rd = !wr;
    cfg_req.wr = wr;
    cfg_req.addr = addr;
    cfg_req.be = be;
    cfg_req.wdata = wdata;
    @(posedge core_clk);
    #1;
    ack = cfg_ack;
    rdata = cfg_rdata;
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
    cfg_req.addr = ~addr;
    cfg_req.be = ~be;
    cfg_req.wdata = ~wdata;
  endtask

  task automatic mem_access(input logic [63:0] addr, output bmwd_pkg::bmwd_fwd_type res);
    @(posedge core_clk);
    #1;
    mem_req.valid = 1'b1;
    mem_req.addr = addr;
    @(posedge core_clk);
    #1;
    res = fwd;
    mem_req.valid = 1'b0;
    mem_req.addr = ~addr;
  endtask
endmodule

// ---- testbench/tb.sv ----
/*
  Self-checking bench of the window decoder: register reset values and access kinds,
  byte lanes, and the claim decision of both windows at their edges.
  Assumes the decoder and host model files are compiled before it.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk;
  logic reset;
  bmwd_pkg::bmwd_cfg_req_type cfg_req;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  bmwd_pkg::bmwd_mem_req_type mem_req;
  bmwd_pkg::bmwd_fwd_type fwd;
  int err_total;
  int samples_checked;

  bmwd_top bmwd_top_inst (
    .core_clk(core_clk),
    .reset(reset),
    .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack),
    .mem_req(mem_req),
    .fwd(fwd)
  );

  bmwd_host_model bmwd_host_model_inst (
    .core_clk(core_clk),
    .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack),
    .mem_req(mem_req),
    .fwd(fwd)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cfg_wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] rd;
    logic ack;
    bmwd_host_model_inst.cfg_access(1'b1, addr, be, d, rd, ack);
    check({63'h0, ack}, 64'h1);
  endtask

  task automatic cfg_rd(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    logic ack;
    bmwd_host_model_inst.cfg_access(1'b0, addr, 4'hF, 32'h0, rd, ack);
    check({63'h0, ack}, 64'h1);
    check({32'h0, rd}, {32'h0, exp});
  endtask

  task automatic probe(input logic [63:0] addr, input logic mm, input logic pf);
    bmwd_pkg::bmwd_fwd_type res;
    bmwd_host_model_inst.mem_access(addr, res);
    check({61'h0, res.valid, res.mmio_hit, res.pref_hit}, {61'h0, mm | pf, mm, pf});
    check(res.addr, addr);
  endtask

  task automatic test_reset_values();
    cfg_rd(8'h20, 32'h0000_0000);
    cfg_rd(8'h24, 32'h0001_0001);
    cfg_rd(8'h28, 32'h0000_0000);
    cfg_rd(8'h2C, 32'h0000_0000);
  endtask

  task automatic test_access_kinds();
    cfg_wr(8'h20, 4'hF, 32'hFFFF_FFFF);
    cfg_rd(8'h20, 32'hFFF0_FFF0);
    cfg_wr(8'h20, 4'h1, 32'h0000_0000);
    cfg_rd(8'h20, 32'hFFF0_FF00);
    cfg_wr(8'h20, 4'hC, 32'h0000_0000);
    cfg_rd(8'h20, 32'h0000_FF00);
    cfg_wr(8'h24, 4'hF, 32'hFFF0_FFF0);
    // both codes equal after write attempt
    cfg_rd(8'h24, 32'hFFF1_FFF1);
    cfg_wr(8'h24, 4'hF, 32'h0000_0000);
    cfg_rd(8'h24, 32'h0001_0001);
    cfg_wr(8'h28, 4'hF, 32'hA5A5_5A5A);
    cfg_rd(8'h28, 32'hA5A5_5A5A);
    cfg_wr(8'h2C, 4'h3, 32'hFFFF_FFFF);
    cfg_rd(8'h2C, 32'h0000_FFFF);
    // Unmapped dword reads zero and ignores writes
    cfg_wr(8'h30, 4'hF, 32'hFFFF_FFFF);
    cfg_rd(8'h30, 32'h0000_0000);
  endtask

  task automatic test_mmio_window();
    cfg_wr(8'h20, 4'hF, 32'h1250_1230);
    cfg_wr(8'h24, 4'hF, 32'h4010_4000);
    cfg_wr(8'h28, 4'hF, 32'h0000_0001);
    cfg_wr(8'h2C, 4'hF, 32'h0000_0001);
    probe(64'h0000_0000_1230_0000, 1'b1, 1'b0);
    probe(64'h0000_0000_122F_FFFF, 1'b0, 1'b0);
    probe(64'h0000_0000_125F_FFFF, 1'b1, 1'b0);
    probe(64'h0000_0000_1240_0000, 1'b1, 1'b0);
    probe(64'h0000_0000_1260_0000, 1'b0, 1'b0);
    probe(64'h0000_0001_1240_0000, 1'b0, 1'b0);
  endtask

  task automatic test_pref_window();
    probe(64'h0000_0001_4000_0000, 1'b0, 1'b1);
    probe(64'h0000_0001_3FFF_FFFF, 1'b0, 1'b0);
    probe(64'h0000_0001_401F_FFFF, 1'b0, 1'b1);
    probe(64'h0000_0001_4020_0000, 1'b0, 1'b0);
    probe(64'h0000_0000_4000_0000, 1'b0, 1'b0);
    probe(64'h0000_0002_4000_0000, 1'b0, 1'b0);
  endtask

  // Reset in mid-run must clear windows that were programmed non-zero
  task automatic test_mid_reset();
    @(posedge core_clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    cfg_rd(8'h20, 32'h0000_0000);
    cfg_rd(8'h24, 32'h0001_0001);
    cfg_rd(8'h28, 32'h0000_0000);
    cfg_rd(8'h2C, 32'h0000_0000);
    probe(64'h0000_0001_4000_0000, 1'b0, 1'b0);
  endtask

  initial begin
    err_total = 0;
    samples_checked = 0;
    reset = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    reset = 1'b0;
    test_reset_values();
    test_access_kinds();
    test_mmio_window();
    test_pref_window();
    test_mid_reset();
    summarize();
  end

  // Whole run needs roughly 100 cycles; allow a wide margin
  initial begin
    #(2000 * 100);
    err_total++;
    summarize();
  end
endmodule
